// ==== ptc_pkg.sv ====
// Package of constants, register map and types for the process timers block
package ptc_pkg;
    localparam int CLK_HZ = 10000000;
    localparam int SEC_NS = 1000000000;
    localparam int CLK_PERIOD_NS = 100;
    localparam int SEC_CYCLES = SEC_NS / CLK_PERIOD_NS;
    localparam logic [16:0] LIMIT_MAX = 17'h1869f;
    localparam logic [9:0] TIME_MAX = 10'h3e7;
    localparam logic [16:0] SEC_PER_DAY = 17'h15180;
    localparam logic [11:0] SEC_PER_HOUR = 12'he10;
    localparam logic [5:0] SEC_PER_MIN = 6'h3c;
    localparam int N_SW = 4;
    localparam int N_DAY = 7;
    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_MASK = 8'h08;
    localparam logic [7:0] REG_WINDOW = 8'h0c;
    localparam logic [7:0] REG_X = 8'h10;
    localparam logic [7:0] REG_W = 8'h14;
    localparam logic [7:0] REG_WASH_IVL = 8'h18;
    localparam logic [7:0] REG_WASH_DUR = 8'h1c;
    localparam logic [7:0] REG_WASH_HOLD = 8'h20;
    localparam logic [7:0] REG_CNT_LIM = 8'h24;
    localparam logic [7:0] REG_CNT_VAL = 8'h28;
    localparam logic [7:0] REG_TIME = 8'h2c;
    localparam logic [7:0] REG_SW_SEL = 8'h30;
    localparam logic [7:0] REG_SW_DATA = 8'h34;
    localparam logic [7:0] REG_OUTS = 8'h38;
    // Control fields
    localparam int CTRL_WASH_EN = 0;
    localparam int CTRL_WASH_LOG = 1;
    localparam int CTRL_START_LOG = 2;
    localparam int CTRL_MODE_LO = 3;
    // Status bits
    localparam int ST_START_EV = 0;
    localparam int ST_WASH_EV = 1;
    localparam int ST_CNT_ALARM = 2;
    localparam int ST_WIN_OUT = 3;
    localparam int ST_W = 4;
    typedef enum logic [1:0] {PTC_CNT_OFF, PTC_CNT_SERVICE, PTC_CNT_HOURS} ptc_mode_t;
    typedef enum {PTC_W_IDLE, PTC_W_WASH, PTC_W_HOLD} ptc_wash_t;
endpackage

// ==== ptc_edge.sv ====
// Two-stage input synchroniser with rising edge detector
`timescale 1ns/1ps
module ptc_edge (
    input wire logic clk_i, // System clock
    input wire logic rst_i, // Sync reset
    input wire logic d_i, // Raw binary input
    output logic lvl_o, // Synchronised level
    output logic rise_o // One-cycle rising pulse
);
    logic s1;
    logic s2;
    logic s3;
    // First stage feeds only the second one
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end else begin
            s1 <= d_i;
            s2 <= s1;
            s3 <= s2;
        end
    end
    assign lvl_o = s2;
    assign rise_o = s2 & ~s3;
endmodule

// ==== ptc_top.sv ====
// Process timers, weekly switch, wash timer and counter with Wishbone registers
`timescale 1ns/1ps
module ptc_top #(
    parameter int SEC_DIV = ptc_pkg::SEC_CYCLES // Cycles per second tick
) (
    input wire logic clk_i, // System clock 10 MHz
    input wire logic rst_i, // Sync reset, active high
    input wire logic [7:0] adr_i, // Wishbone byte address
    input wire logic [31:0] dat_i, // Wishbone write data
    input wire logic [3:0] sel_i, // Wishbone byte selects
    input wire logic we_i, // Wishbone write
    input wire logic cyc_i, // Wishbone cycle
    input wire logic stb_i, // Wishbone strobe
    output logic [31:0] dat_o, // Wishbone read data
    output logic ack_o, // Wishbone acknowledge
    input wire logic start_i, // Timer start binary signal
    input wire logic cnt_in_i, // Counter binary input
    output logic timer_run_o, // Gated timer may run
    output logic ctl_out_o, // Weekly control timer output
    output logic wash_o, // Wash output
    output logic hold_o, // Wash hold output
    output logic alarm_o, // Counter limit alarm
    output logic irq_o // Interrupt level
);
    import ptc_pkg::*;

    // ****************************************
    // Registers and bus decode
    // ****************************************
    logic [4:0] ctrl;
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] mask;
    logic [16:0] window;
    logic signed [17:0] sig_x;
    logic signed [17:0] sig_w;
    logic [9:0] wash_ivl;
    logic [9:0] wash_dur;
    logic [9:0] wash_hold;
    logic [16:0] cnt_lim;
    logic [16:0] cnt_val;
    logic [2:0] day;
    logic [16:0] tod;
    logic [5:0] sw_sel;
    logic [16:0] sw_on [N_DAY][N_SW];
    logic [16:0] sw_off [N_DAY][N_SW];
    logic [N_DAY*N_SW-1:0] on_valid;
    logic [N_DAY*N_SW-1:0] off_valid;
    logic [31:0] next_dat;

    wire bus_req = cyc_i & stb_i & ~ack_o;
    wire wr = bus_req & we_i & sel_i[0];
    wire [2:0] sel_day = sw_sel[5:3];
    wire [1:0] sel_idx = sw_sel[1:0];
    wire sel_off = sw_sel[2];
    wire sel_ok = sel_day < 3'(N_DAY);
    wire ptc_mode_t mode = ptc_mode_t'(ctrl[CTRL_MODE_LO +: 2]);

    // Clamp a written value to a configured ceiling
    function automatic logic [16:0] clamp17(input logic [31:0] v, input logic [16:0] mx);
        clamp17 = (v > {15'h0, mx}) ? mx : v[16:0];
    endfunction

    // ****************************************
    // Second tick divider
    // ****************************************
    logic [23:0] div;
    logic tick;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div <= 24'h0;
            tick <= 1'b0;
        end else begin
            tick <= (div == 24'(SEC_DIV - 1));
            div <= (div == 24'(SEC_DIV - 1)) ? 24'h0 : div + 24'h1;
        end
    end

    // ****************************************
    // Synchronised binary inputs
    // ****************************************
    logic start_lvl;
    logic start_rise;
    logic cnt_lvl;
    logic cnt_rise;
    ptc_edge u_start (.clk_i(clk_i), .rst_i(rst_i), .d_i(start_i),
        .lvl_o(start_lvl), .rise_o(start_rise));
    ptc_edge u_cnt (.clk_i(clk_i), .rst_i(rst_i), .d_i(cnt_in_i),
        .lvl_o(cnt_lvl), .rise_o(cnt_rise));

    // ****************************************
    // Tolerance band gate
    // ****************************************
    wire signed [18:0] dev = 19'(sig_x) - 19'(sig_w);
    wire [18:0] dev_abs = dev[18] ? 19'(-dev) : 19'(dev);
    wire in_band = dev_abs <= {2'b00, window};
    logic started;
    // Start only allowed in band; a running timer pauses out of band
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            started <= 1'b0;
            timer_run_o <= 1'b0;
        end else begin
            if (start_rise && in_band) begin
                started <= 1'b1;
            end else if (!start_lvl) begin
                started <= 1'b0;
            end
            timer_run_o <= (started | (start_rise & in_band)) & in_band;
        end
    end

    // ****************************************
    // Weekly control timer
    // ****************************************
    // Time of day and weekday advance on the second tick
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tod <= 17'h0;
            day <= 3'h0;
        end else if (wr && adr_i == REG_TIME) begin
            tod <= clamp17(dat_i & 32'h1ffff, SEC_PER_DAY - 17'h1);
            day <= (dat_i[26:24] < 3'(N_DAY)) ? dat_i[26:24] : 3'h0;
        end else if (tick) begin
            if (tod == SEC_PER_DAY - 17'h1) begin
                tod <= 17'h0;
                day <= (day == 3'(N_DAY - 1)) ? 3'h0 : day + 3'h1;
            end else begin
                tod <= tod + 17'h1;
            end
        end
    end

    // Match of a switch time at the current second for the current day
    logic hit_on;
    logic hit_off;
    always_comb begin
        hit_on = 1'b0;
        hit_off = 1'b0;
        for (int i = 0; i < N_SW; i++) begin
            if (on_valid[day*N_SW + i] && sw_on[day][i] == tod) hit_on = 1'b1;
            if (off_valid[day*N_SW + i] && sw_off[day][i] == tod) hit_off = 1'b1;
        end
    end

    // Off wins when on and off share a second
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl_out_o <= 1'b0;
        end else if (tick && hit_off) begin
            ctl_out_o <= 1'b0;
        end else if (tick && hit_on) begin
            ctl_out_o <= 1'b1;
        end
    end

    // ****************************************
    // Wash timer
    // ****************************************
    ptc_wash_t wstate;
    logic [21:0] wcnt;
    wire wash_en = ctrl[CTRL_WASH_EN];
    wire [21:0] ivl_s = 22'(wash_ivl) * 22'(SEC_PER_HOUR);
    wire [21:0] dur_s = 22'(wash_dur) * 22'(SEC_PER_MIN);
    logic wash_start;
    // Interval counts from the end of the previous hold
    always_ff @(posedge clk_i) begin
        if (rst_i || !wash_en) begin
            wstate <= PTC_W_IDLE;
            wcnt <= 22'h0;
            wash_o <= 1'b0;
            hold_o <= 1'b0;
            wash_start <= 1'b0;
        end else begin
            wash_start <= 1'b0;
            if (tick) begin
                case (wstate)
                    PTC_W_IDLE: begin
                        if (wcnt + 22'h1 >= ivl_s) begin
                            wcnt <= 22'h0;
                            wstate <= PTC_W_WASH;
                            wash_o <= (dur_s != 22'h0);
                            hold_o <= 1'b1;
                            wash_start <= 1'b1;
                        end else begin
                            wcnt <= wcnt + 22'h1;
                        end
                    end
                    PTC_W_WASH: begin
                        // Count the tick that ends the second, so a wash is dur_s long
                        if (wcnt + 22'h1 >= dur_s) begin
                            wash_o <= 1'b0;
                            wcnt <= 22'h0;
                            wstate <= PTC_W_HOLD;
                        end else begin
                            wcnt <= wcnt + 22'h1;
                        end
                    end
                    PTC_W_HOLD: begin
                        if (wcnt + 22'h1 >= 22'(wash_hold)) begin
                            hold_o <= 1'b0;
                            wcnt <= 22'h0;
                            wstate <= PTC_W_IDLE;
                        end else begin
                            wcnt <= wcnt + 22'h1;
                        end
                    end
                    default: wstate <= PTC_W_IDLE;
                endcase
            end
        end
    end

    // ****************************************
    // Service and operating-hours counter
    // ****************************************
    logic [11:0] on_secs;
    always_ff @(posedge clk_i) begin
        if (rst_i || mode == PTC_CNT_OFF) begin
            cnt_val <= 17'h0;
            on_secs <= 12'h0;
            alarm_o <= 1'b0;
        end else begin
            if (mode == PTC_CNT_SERVICE && cnt_rise && cnt_val != LIMIT_MAX) begin
                cnt_val <= cnt_val + 17'h1;
            end
            if (mode == PTC_CNT_HOURS && tick && cnt_lvl) begin
                if (on_secs == SEC_PER_HOUR - 12'h1) begin
                    on_secs <= 12'h0;
                    if (cnt_val != LIMIT_MAX) cnt_val <= cnt_val + 17'h1;
                end else begin
                    on_secs <= on_secs + 12'h1;
                end
            end
            alarm_o <= cnt_val >= cnt_lim;
        end
    end

    // ****************************************
    // Status, interrupt and register writes
    // ****************************************
    wire [ST_W-1:0] ev = {~in_band, alarm_o, wash_start & ctrl[CTRL_WASH_LOG],
        start_rise & ctrl[CTRL_START_LOG]};
    wire [ST_W-1:0] w1c = (wr && adr_i == REG_STATUS) ? dat_i[ST_W-1:0] : '0;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status <= '0;
            irq_o <= 1'b0;
        end else begin
            status <= (status & ~w1c) | ev; // Set beats clear
            irq_o <= |(status & mask);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= 5'h0;
            mask <= '0;
            window <= 17'h0;
            sig_x <= 18'sh0;
            sig_w <= 18'sh0;
            wash_ivl <= 10'h0;
            wash_dur <= 10'h0;
            wash_hold <= 10'h0;
            cnt_lim <= 17'h0;
            sw_sel <= 6'h0;
            on_valid <= '0;
            off_valid <= '0;
        end else if (wr) begin
            case (adr_i)
                REG_CTRL: ctrl <= dat_i[4:0];
                REG_MASK: mask <= dat_i[ST_W-1:0];
                REG_WINDOW: window <= clamp17(dat_i, LIMIT_MAX);
                REG_X: sig_x <= dat_i[17:0];
                REG_W: sig_w <= dat_i[17:0];
                REG_WASH_IVL: wash_ivl <= 10'(clamp17(dat_i, 17'(TIME_MAX)));
                REG_WASH_DUR: wash_dur <= 10'(clamp17(dat_i, 17'(TIME_MAX)));
                REG_WASH_HOLD: wash_hold <= 10'(clamp17(dat_i, 17'(TIME_MAX)));
                REG_CNT_LIM: cnt_lim <= clamp17(dat_i, LIMIT_MAX);
                REG_SW_SEL: sw_sel <= dat_i[5:0];
                REG_SW_DATA: begin
                    if (sel_ok && sel_off) off_valid[sel_day*N_SW + sel_idx] <= dat_i[31];
                    if (sel_ok && !sel_off) on_valid[sel_day*N_SW + sel_idx] <= dat_i[31];
                end
                default: ;
            endcase
        end
    end

    // Switch time table: no reset, guarded by valid bits
    always_ff @(posedge clk_i) begin
        if (wr && adr_i == REG_SW_DATA && sel_ok) begin
            if (sel_off) sw_off[sel_day][sel_idx] <= clamp17(dat_i & 32'h1ffff,
                SEC_PER_DAY - 17'h1);
            else sw_on[sel_day][sel_idx] <= clamp17(dat_i & 32'h1ffff, SEC_PER_DAY - 17'h1);
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        case (adr_i)
            REG_CTRL: next_dat = {27'h0, ctrl};
            REG_STATUS: next_dat = {28'h0, status};
            REG_MASK: next_dat = {28'h0, mask};
            REG_WINDOW: next_dat = {15'h0, window};
            REG_X: next_dat = 32'(sig_x);
            REG_W: next_dat = 32'(sig_w);
            REG_WASH_IVL: next_dat = {22'h0, wash_ivl};
            REG_WASH_DUR: next_dat = {22'h0, wash_dur};
            REG_WASH_HOLD: next_dat = {22'h0, wash_hold};
            REG_CNT_LIM: next_dat = {15'h0, cnt_lim};
            REG_CNT_VAL: next_dat = {15'h0, cnt_val};
            REG_TIME: next_dat = {5'h0, day, 7'h0, tod};
            REG_SW_SEL: next_dat = {26'h0, sw_sel};
            REG_OUTS: next_dat = {26'h0, wstate == PTC_W_IDLE, alarm_o, hold_o, wash_o,
                ctl_out_o, timer_run_o};
            default: next_dat = 32'h0;
        endcase
    end

    // One wait-free ack per request, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0;
        end else begin
            ack_o <= bus_req;
            dat_o <= bus_req ? next_dat : 32'h0;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    gate_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !in_band |=> !timer_run_o) else $error("timer ran outside band");
    gate_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (start_rise && in_band) |=> timer_run_o || !in_band) else $error("start lost");
    ctl_on_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (tick && hit_on && !hit_off) |=> ctl_out_o) else $error("switch-on missed");
    ctl_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (tick && hit_off) |=> !ctl_out_o) else $error("switch-off missed");
    wash_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !wash_en |=> !wash_o && !hold_o) else $error("wash active while disabled");
    wash_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wash_o |-> hold_o) else $error("hold dropped during wash");
    svc_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode == PTC_CNT_SERVICE && $past(mode) == PTC_CNT_SERVICE && cnt_rise
        && cnt_val < LIMIT_MAX && !wr) |=> cnt_val == $past(cnt_val) + 17'h1)
        else $error("edge not counted");
    cnt_alarm_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode != PTC_CNT_OFF && cnt_val >= cnt_lim && $stable(mode)) |=> ##1 alarm_o
        || mode == PTC_CNT_OFF || cnt_val < cnt_lim) else $error("alarm missing");
    sync_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        cnt_rise |=> !cnt_rise) else $error("double edge pulse");
endmodule

// ==== ptc_sel_model.sv ====
// Model of the binary selectors that feed the start and counter inputs
`timescale 1ns/1ps
module ptc_sel_model (
    input wire logic clk_i, // System clock
    output logic start_o, // Timer start level
    output logic cnt_o // Counter input level
);
    // Idle low from time zero, so reset release shows no edge
    initial begin
        start_o = 1'b0;
        cnt_o = 1'b0;
    end
    // Levels change right after a rising edge only
    task set_start(input logic v);
        start_o <= v;
        @(posedge clk_i);
    endtask
    task set_cnt(input logic v);
        cnt_o <= v;
        @(posedge clk_i);
    endtask
    // Three cycles per phase, longer than the synchroniser delay
    task pulse_cnt(input int n);
        repeat (n) begin
            cnt_o <= 1'b1;
            repeat (3) @(posedge clk_i);
            cnt_o <= 1'b0;
            repeat (3) @(posedge clk_i);
        end
    endtask
endmodule

// ==== test_process_timers_and_counters.sv ====
// Register-level testbench for the process timers block
`timescale 1ns/1ps
module test_process_timers_and_counters;
    import ptc_pkg::*;
    // Short second tick keeps the hour count inside the run
    localparam int DIV = 10;
    localparam int LIMIT = 60000;
    logic clk_i, rst_i, we_i, cyc_i, stb_i, ack_o, start_i, cnt_in_i;
    logic timer_run_o, ctl_out_o, wash_o, hold_o, alarm_o, irq_o;
    logic [7:0] adr_i;
    logic [31:0] dat_i, dat_o, rdat;
    logic [3:0] sel_i;
    logic [3:0] be;
    logic [7:0] clamp_adr [3] = '{REG_WASH_IVL, REG_WASH_DUR, REG_WASH_HOLD};
    int fails, comparisons, cyc_n, t;

    ptc_top #(.SEC_DIV(DIV)) dut (.clk_i, .rst_i, .adr_i, .dat_i, .sel_i, .we_i, .cyc_i,
        .stb_i, .dat_o, .ack_o, .start_i, .cnt_in_i, .timer_run_o, .ctl_out_o, .wash_o,
        .hold_o, .alarm_o, .irq_o);
    ptc_sel_model sel_m (.clk_i, .start_o(start_i), .cnt_o(cnt_in_i));

    // ****************************************
    // Clock, timeout and shared tasks
    // ****************************************
    initial clk_i = 1'b0;
    always #50 clk_i = ~clk_i;
    // A hang counts as a mismatch and ends the run
    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == LIMIT) begin
            fails++;
            $display("CHECK FAILED at %0t: timeout", $time);
            conclude();
        end
    end
    task chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, s, e);
        end
    endtask
    task ok(input logic c);
        chk({31'h0, c}, 32'h1);
    endtask
    function automatic logic near(input int v, input int e, input int d);
        return (v >= e - d) && (v <= e + d);
    endfunction
    // Classic cycle: hold until ack is sampled, then one idle cycle
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        adr_i <= a;
        dat_i <= d;
        we_i <= w;
        sel_i <= be;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        rdat = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task rd(input logic [7:0] a);
        bus(1'b0, a, 32'h0);
    endtask
    // Polls one output bit through the register bus; t is cycles taken
    task poll(input int b, input logic v, input int n, output int tt);
        int s;
        s = cyc_n;
        rd(REG_OUTS);
        while (rdat[b] !== v && n > 0) begin
            rd(REG_OUTS);
            n--;
        end
        tt = cyc_n - s;
        chk({31'h0, rdat[b]}, {31'h0, v});
    endtask
    task conclude();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        rst_i = 1'b1;
        {we_i, cyc_i, stb_i} = 3'h0;
        adr_i = 8'h0;
        dat_i = 32'h0;
        sel_i = 4'h0;
        be = 4'hf;
        {fails, comparisons, cyc_n} = '0;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        ok({timer_run_o, ctl_out_o, wash_o, hold_o, alarm_o, irq_o} === 6'h0);
        rd(REG_CTRL);
        chk(rdat, 32'h0);
        wr(8'h3c, 32'hffffffff);
        rd(8'h3c);
        chk(rdat, 32'h0);
        wr(REG_CNT_VAL, 32'h5);
        rd(REG_CNT_VAL);
        chk(rdat, 32'h0);
        wr(REG_WINDOW, 32'h1ffff);
        rd(REG_WINDOW);
        chk(rdat, {15'h0, LIMIT_MAX});
        // A write without the low byte lane is ignored
        be = 4'he;
        wr(REG_WINDOW, 32'h1);
        be = 4'hf;
        rd(REG_WINDOW);
        chk(rdat, {15'h0, LIMIT_MAX});
        for (int i = 0; i < 3; i++) begin
            wr(clamp_adr[i], 32'hfff);
            rd(clamp_adr[i]);
            chk(rdat, {22'h0, TIME_MAX});
        end
        $display("test reset and clamps done");
        // Start while out of band is refused; edge in band at the limit runs
        wr(REG_CTRL, 32'h4);
        wr(REG_MASK, 32'h1);
        wr(REG_X, 32'h64);
        wr(REG_W, 32'h5a);
        wr(REG_WINDOW, 32'h5);
        sel_m.set_start(1'b1);
        repeat (8) @(posedge clk_i);
        ok(timer_run_o === 1'b0);
        sel_m.set_start(1'b0);
        wr(REG_STATUS, 32'hf);
        wr(REG_W, 32'h5f);
        sel_m.set_start(1'b1);
        poll(0, 1'b1, 10, t);
        rd(REG_STATUS);
        ok(rdat[0] === 1'b1);
        ok(rdat[3] === 1'b1);
        ok(irq_o === 1'b1);
        wr(REG_MASK, 32'h0);
        ok(irq_o === 1'b0);
        wr(REG_MASK, 32'h1);
        wr(REG_STATUS, 32'h1);
        rd(REG_STATUS);
        ok(rdat[0] === 1'b0 && irq_o === 1'b0);
        wr(REG_W, 32'h5e);
        poll(0, 1'b0, 10, t);
        wr(REG_W, 32'h69);
        poll(0, 1'b1, 10, t);
        sel_m.set_start(1'b0);
        $display("test gate done");
        // Service count: limit zero, then three edges against limit three
        wr(REG_CTRL, 32'h8);
        wr(REG_CNT_LIM, 32'h0);
        ok(alarm_o === 1'b1);
        wr(REG_CNT_LIM, 32'h3);
        sel_m.pulse_cnt(2);
        rd(REG_CNT_VAL);
        chk(rdat, 32'h2);
        ok(alarm_o === 1'b0);
        sel_m.pulse_cnt(1);
        rd(REG_CNT_VAL);
        chk(rdat, 32'h3);
        ok(alarm_o === 1'b1);
        rd(REG_STATUS);
        ok(rdat[2] === 1'b1);
        wr(REG_CTRL, 32'h0);
        sel_m.pulse_cnt(1);
        rd(REG_CNT_VAL);
        chk(rdat, 32'h0);
        ok(alarm_o === 1'b0);
        $display("test service count done");
        // Day 2 on at 103 s, off at 106 s; a day 3 entry at 101 s must not act
        wr(REG_SW_SEL, 32'h10);
        wr(REG_SW_DATA, 32'h80000067);
        wr(REG_SW_SEL, 32'h15);
        wr(REG_SW_DATA, 32'h8000006a);
        wr(REG_SW_SEL, 32'h18);
        wr(REG_SW_DATA, 32'h80000065);
        wr(REG_TIME, 32'h02000064);
        poll(1, 1'b1, 40, t);
        ok(near(t, 3 * DIV, DIV + 8));
        poll(1, 1'b0, 40, t);
        ok(near(t, 3 * DIV, DIV + 8) && ctl_out_o === 1'b0);
        $display("test weekly switch done");
        // Wash of one minute, hold two seconds, interval zero repeats
        wr(REG_WASH_IVL, 32'h0);
        wr(REG_WASH_DUR, 32'h1);
        wr(REG_WASH_HOLD, 32'h2);
        wr(REG_STATUS, 32'hf);
        wr(REG_CTRL, 32'h3);
        poll(2, 1'b1, 20, t);
        poll(2, 1'b0, 260, t);
        ok(near(t, 60 * DIV, DIV + 8) && hold_o === 1'b1);
        poll(3, 1'b0, 20, t);
        ok(near(t, 2 * DIV, DIV + 8));
        rd(REG_STATUS);
        ok(rdat[1] === 1'b1);
        poll(2, 1'b1, 20, t);
        wr(REG_CTRL, 32'h0);
        repeat (5 * DIV) @(posedge clk_i);
        ok(wash_o === 1'b0 && hold_o === 1'b0);
        $display("test wash done");
        // One hour of on-time reaches a limit of one hour
        wr(REG_CNT_LIM, 32'h1);
        wr(REG_CTRL, 32'h10);
        sel_m.set_cnt(1'b1);
        poll(4, 1'b1, 13000, t);
        ok(near(t, 3600 * DIV, 2 * DIV + 8));
        rd(REG_CNT_VAL);
        chk(rdat, 32'h1);
        sel_m.set_cnt(1'b0);
        $display("test operating hours done");
        conclude();
    end
endmodule
